// *** shared/do8_params.svh ***
// Offsets, field values, reset values and timing counts of the output block
// ----------------------------------------------------------------------------
// How it works
// - Eight channels, each with its own mode, unconfigured after reset.
// - Mode is on-off, threshold, PWM or PFM; only its own parameters apply.
// - On-off mode drives only on or off, following the input value.
// - PWM mode has a fast variant and a slow variant.
// - PFM mode sets output frequency from the input value.
// - On error the output goes to fallback: last value, off or on.
// - Inversion drives the complement of the computed output; off after reset.
// - A configurable delay sits between input change and output switch; default zero.
// - A pulse shorter than the delay leaves the output unchanged.
// - After the hold time of steady on, power reduction swaps on for PWM.
// - Power reduction has a hold time and a duty cycle in percent.
// - Threshold scheme is hysteresis or window; hysteresis after reset.
// - Threshold lower and upper limits, 0 and 100 after reset.
// - Short-circuit detection enabled per channel, on after reset.
// - Window scheme switches on inside the band, off outside it.
// ----------------------------------------------------------------------------
`ifndef DO8_PARAMS_SVH
`define DO8_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define DO_NCH           8
`define DO_CFG_PAGE      3'h0
`define DO_LIM_PAGE      3'h1
`define DO_STAT_ADDR     8'h40
`define DO_MASK_ADDR     8'h44
`define DO_LIVE_ADDR     8'h48
`define DO_CFG_WMASK     32'hff01ffff
`define DO_CFG_RST       32'h00000140
`define DO_LIM_RST       32'h00006400

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DO_CLK_MHZ       100
`define DO_TICK_US       1000
`define DO_TICK_CYC      (`DO_TICK_US * `DO_CLK_MHZ)
`define DO_PWM_STEPS     7'd100
`define DO_FAST_HZ       2000
`define DO_FAST_STEP_CYC (`DO_CLK_MHZ * 1000000 / `DO_FAST_HZ / 100)
`define DO_SLOW_US       60000000
`define DO_SLOW_STEP_CYC (`DO_SLOW_US / 100 * `DO_CLK_MHZ)

`endif

// *** shared/do8_pkg.sv ***
// Types shared by the digital output block
package do8_pkg;

    typedef enum logic [2:0] {
        MODE_UNCONF = 3'h0,
        MODE_ONOFF  = 3'h1,
        MODE_THRESH = 3'h2,
        MODE_PWM    = 3'h3,
        MODE_PFM    = 3'h4
    } mode_t;

    typedef enum logic [1:0] {
        FB_LAST = 2'h0,
        FB_OFF  = 2'h1,
        FB_ON   = 2'h2
    } fallback_t;

    typedef enum logic [2:0] {
        PR_OFF  = 3'h1,
        PR_HOLD = 3'h2,
        PR_RED  = 3'h4
    } pr_state_t;

    typedef struct packed {
        logic [7:0] delay;
        logic [6:0] rsvd;
        logic [6:0] duty;
        logic       pr_en;
        logic       sc_en;
        fallback_t  fb;
        logic       inv;
        logic       win;
        logic       slow;
        mode_t      mode;
    } cfg_t;

    typedef struct packed {
        logic [15:0] reduction_hold_time;
        logic [7:0]  upper;
        logic [7:0]  lower;
    } lim_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        filt;
        logic        hyst;
        logic        last;
        logic        out;
        pr_state_t   pst;
        logic [7:0]  dly;
        logic [15:0] hold;
        logic [15:0] acc;
    } ch_state_t;

    typedef struct packed {
        cfg_t      [7:0] cfg;
        lim_t      [7:0] lim;
        ch_state_t [7:0] ch;
        logic [15:0]     stat;
        logic [15:0]     mask;
        logic [16:0]     tick_cnt;
        logic [8:0]      fast_cnt;
        logic [25:0]     slow_cnt;
        logic            tick;
        logic            fast;
        logic            slow;
        logic [31:0]     rdata;
        logic            irq;
    } top_state_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic       out;
    } pwm_state_t;

endpackage

// *** design/duty_pwm.sv ***
// Percent-duty PWM generator stepped by an external pulse
`include "do8_params.svh"

module duty_pwm
    import do8_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       step,
    input  wire logic [6:0] duty,
    output logic            pwm
);

    pwm_state_t s;
    pwm_state_t n;

    // ------------------------------------------------------------------------
    // Counter of 100 steps; duty of 100 or more keeps the output high
    // ------------------------------------------------------------------------
    always_comb
    begin
        n = s;
        if (step)
        begin
            n.cnt = (s.cnt == `DO_PWM_STEPS - 7'h1) ? 7'h0 : s.cnt + 7'h1;
        end
        n.out = n.cnt < duty;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= n;
    end

    assign pwm = s.out;

    property p_pwm_zero;
        @(posedge mclk) disable iff (!resetn)
        (duty == 7'h0) |=> !pwm;
    endproperty
    a_pwm_zero : assert property (p_pwm_zero) else $error("pwm high at zero duty");

endmodule

// *** design/do8_ctrl.sv ***
// Eight-channel digital output stage with register port and interrupt
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "do8_params.svh"

module do8_ctrl
    import do8_pkg::*;
#(
    parameter int TICK_CYC = `DO_TICK_CYC,
    parameter int SLOW_CYC = `DO_SLOW_STEP_CYC
)(
    input  wire logic            mclk,
    input  wire logic            resetn,
    input  wire reg_req_t        req,
    output logic [31:0]          rdata,
    input  wire logic [7:0][7:0] proc_value,
    input  wire logic [7:0]      fault_in,
    input  wire logic [7:0]      short_in,
    output logic [7:0]           act_out,
    output logic                 irq
);

    top_state_t s;
    top_state_t n;
    logic [7:0] pwm_mod;
    logic [7:0] pwm_red;
    logic [7:0] clean;

    // ------------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------------
    function automatic logic [2:0] chan(input logic [7:0] a);
        return a[4:2];
    endfunction

    function automatic logic in_page(input logic [7:0] a, input logic [2:0] p);
        return a[7:5] == p && a[1:0] == 2'h0;
    endfunction

    // ------------------------------------------------------------------------
    // Modulators: one for the PWM mode, one for power reduction
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < `DO_NCH; g++)
    begin : g_ch
        logic [6:0] dm;
        assign dm = (proc_value[g] > 8'd100) ? `DO_PWM_STEPS : proc_value[g][6:0];

        duty_pwm u_mod (
            .mclk   (mclk),
            .resetn (resetn),
            .step   (s.cfg[g].slow ? s.slow : s.fast),
            .duty   (dm),
            .pwm    (pwm_mod[g])
        );

        duty_pwm u_red (
            .mclk   (mclk),
            .resetn (resetn),
            .step   (s.fast),
            .duty   (s.cfg[g].duty),
            .pwm    (pwm_red[g])
        );

        assign act_out[g] = s.ch[g].out;
        assign clean[g] = s.cfg[g].delay == 8'h0 && !s.cfg[g].pr_en && !s.cfg[g].inv
                          && !fault_in[g] && !(s.cfg[g].sc_en && short_in[g]);
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        cfg_t        c;
        lim_t        m;
        ch_state_t   cs;
        logic [7:0]  v;
        logic        e;
        logic        w;
        logic        f;
        logic        l;
        logic [15:0] set;
        logic [15:0] clr;
        logic [15:0] live;
        c = '0;
        m = '0;
        cs = '0;
        v = '0;
        e = 1'b0;
        w = 1'b0;
        f = 1'b0;
        l = 1'b0;
        set = '0;
        clr = '0;
        live = '0;
        n = s;

        // Time bases: 1 ms tick, fast and slow PWM steps
        n.tick = s.tick_cnt == 17'(TICK_CYC - 1);
        n.tick_cnt = n.tick ? 17'h0 : s.tick_cnt + 17'h1;
        n.fast = s.fast_cnt == 9'(`DO_FAST_STEP_CYC - 1);
        n.fast_cnt = n.fast ? 9'h0 : s.fast_cnt + 9'h1;
        n.slow = s.slow_cnt == 26'(SLOW_CYC - 1);
        n.slow_cnt = n.slow ? 26'h0 : s.slow_cnt + 26'h1;

        // Register writes
        if (req.wr)
        begin
            if (in_page(req.addr, `DO_CFG_PAGE))
                n.cfg[chan(req.addr)] = cfg_t'(req.wdata & `DO_CFG_WMASK);
            else if (in_page(req.addr, `DO_LIM_PAGE))
                n.lim[chan(req.addr)] = lim_t'(req.wdata);
            else if (req.addr == `DO_STAT_ADDR)
                clr = req.wdata[15:0];
            else if (req.addr == `DO_MASK_ADDR)
                n.mask = req.wdata[15:0];
        end

        for (int i = 0; i < `DO_NCH; i++)
        begin
            c = s.cfg[i];
            m = s.lim[i];
            cs = s.ch[i];
            v = proc_value[i];
            e = fault_in[i] | (c.sc_en & short_in[i]);
            set[i] = c.sc_en & short_in[i];
            set[8 + i] = e;

            // Raw decision of the selected mode only
            case (c.mode)
                MODE_ONOFF:
                    w = v != 8'h0;
                MODE_THRESH:
                begin
                    if (c.win)
                        w = v >= m.lower && v <= m.upper;
                    else if (v > m.upper)
                        w = 1'b1;
                    else if (v < m.lower)
                        w = 1'b0;
                    else
                        w = cs.hyst;
                end
                MODE_PWM:
                    w = pwm_mod[i];
                MODE_PFM:
                    w = cs.acc[15];
                default:
                    w = 1'b0;
            endcase
            n.ch[i].hyst = w;

            // Phase accumulator overflows faster for larger inputs
            if (s.fast)
                n.ch[i].acc = cs.acc + {8'h0, v};

            // Switching delay; a change undone in time is dropped
            f = cs.filt;
            if (w == cs.filt)
            begin
                n.ch[i].dly = 8'h0;
            end
            else if (cs.dly >= c.delay)
            begin
                f = w;
                n.ch[i].dly = 8'h0;
            end
            else if (s.tick)
            begin
                n.ch[i].dly = cs.dly + 8'h1;
            end
            n.ch[i].filt = f;

            // Power reduction after a steady on
            case (cs.pst)
                PR_OFF:
                begin
                    if (f)
                    begin
                        n.ch[i].pst = PR_HOLD;
                        n.ch[i].hold = 16'h0;
                    end
                end
                PR_HOLD:
                begin
                    if (!f)
                        n.ch[i].pst = PR_OFF;
                    else if (c.pr_en && cs.hold >= m.reduction_hold_time)
                        n.ch[i].pst = PR_RED;
                    else if (s.tick && cs.hold != 16'hffff)
                        n.ch[i].hold = cs.hold + 16'h1;
                end
                PR_RED:
                begin
                    if (!f || !c.pr_en)
                        n.ch[i].pst = PR_OFF;
                end
                default:
                    n.ch[i].pst = PR_OFF;
            endcase

            // Modulated modes bypass delay and reduction
            if (c.mode == MODE_PWM || c.mode == MODE_PFM)
                l = w;
            else if (cs.pst == PR_RED && c.pr_en)
                l = f & pwm_red[i];
            else
                l = f;
            l = l ^ c.inv;
            if (c.mode == MODE_UNCONF)
                l = 1'b0;

            // Error fallback
            if (e)
            begin
                case (c.fb)
                    FB_ON:
                        n.ch[i].out = 1'b1;
                    FB_OFF:
                        n.ch[i].out = 1'b0;
                    default:
                        n.ch[i].out = cs.last;
                endcase
            end
            else
            begin
                n.ch[i].out = l;
                n.ch[i].last = l;
            end

            live[i] = cs.out;
            live[8 + i] = cs.pst == PR_RED;
        end

        // A set arriving with its clear wins
        n.stat = (s.stat & ~clr) | set;
        n.irq = |(n.stat & n.mask);

        // Read data stands in the cycle after the strobe only
        n.rdata = 32'h0;
        if (req.rd)
        begin
            if (in_page(req.addr, `DO_CFG_PAGE))
                n.rdata = s.cfg[chan(req.addr)];
            else if (in_page(req.addr, `DO_LIM_PAGE))
                n.rdata = s.lim[chan(req.addr)];
            else if (req.addr == `DO_STAT_ADDR)
                n.rdata = {16'h0, s.stat};
            else if (req.addr == `DO_MASK_ADDR)
                n.rdata = {16'h0, s.mask};
            else if (req.addr == `DO_LIVE_ADDR)
                n.rdata = {16'h0, live};
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s <= '0;
            for (int i = 0; i < `DO_NCH; i++)
            begin
                s.cfg[i] <= cfg_t'(`DO_CFG_RST);
                s.lim[i] <= lim_t'(`DO_LIM_RST);
                s.ch[i].pst <= PR_OFF;
            end
        end
        else
        begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign irq = s.irq;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    for (genvar g = 0; g < `DO_NCH; g++)
    begin : g_chk
        logic err;
        assign err = fault_in[g] | (s.cfg[g].sc_en & short_in[g]);

        property p_unconf;
            s.cfg[g].mode == MODE_UNCONF && !err |=> !act_out[g];
        endproperty
        a_unconf : assert property (p_unconf) else $error("unconfigured drives");

        property p_onoff;
            s.cfg[g].mode == MODE_ONOFF && clean[g]
            |=> act_out[g] == ($past(proc_value[g]) != 8'h0);
        endproperty
        a_onoff : assert property (p_onoff) else $error("on-off mismatch");

        property p_inv;
            s.cfg[g].mode == MODE_ONOFF && s.cfg[g].inv && s.cfg[g].delay == 8'h0
            && !s.cfg[g].pr_en && !err
            |=> act_out[g] == ($past(proc_value[g]) == 8'h0);
        endproperty
        a_inv : assert property (p_inv) else $error("inversion wrong");

        property p_fb;
            // Code 3 behaves as last value, so only the forced codes are judged here
            err && (s.cfg[g].fb == FB_ON || s.cfg[g].fb == FB_OFF)
            |=> act_out[g] == ($past(s.cfg[g].fb) == FB_ON);
        endproperty
        a_fb : assert property (p_fb) else $error("fallback wrong");

        property p_short;
            // A mask write in the same cycle may legally drop the interrupt
            s.cfg[g].sc_en && short_in[g] && s.mask[g]
            && !(req.wr && req.addr == `DO_MASK_ADDR)
            |=> s.stat[g] && irq;
        endproperty
        a_short : assert property (p_short) else $error("short not flagged");

        property p_win;
            s.cfg[g].mode == MODE_THRESH && s.cfg[g].win && clean[g]
            |=> act_out[g] == ($past(proc_value[g]) >= $past(s.lim[g].lower)
                               && $past(proc_value[g]) <= $past(s.lim[g].upper));
        endproperty
        a_win : assert property (p_win) else $error("window wrong");

        property p_hyst;
            s.cfg[g].mode == MODE_THRESH && !s.cfg[g].win && clean[g]
            && proc_value[g] > s.lim[g].upper ##1
            s.cfg[g].mode == MODE_THRESH && !s.cfg[g].win && clean[g]
            && proc_value[g] >= s.lim[g].lower
            |=> act_out[g];
        endproperty
        a_hyst : assert property (p_hyst) else $error("hysteresis lost");

        property p_delay;
            s.cfg[g].mode == MODE_ONOFF && s.cfg[g].delay != 8'h0
            && !s.ch[g].filt && s.ch[g].dly == 8'h0 && proc_value[g] != 8'h0
            |=> !s.ch[g].filt;
        endproperty
        a_delay : assert property (p_delay) else $error("delay skipped");

        property p_red;
            s.ch[g].pst == PR_HOLD && !s.cfg[g].pr_en |=> s.ch[g].pst != PR_RED;
        endproperty
        a_red : assert property (p_red) else $error("reduction while off");
    end

    c_short : cover property (short_in[0] && s.cfg[0].sc_en);
    c_reduce : cover property (s.ch[0].pst == PR_RED && act_out[0]);
    c_pwm : cover property (s.cfg[1].mode == MODE_PWM && $rose(act_out[1]));
    c_pfm : cover property (s.cfg[2].mode == MODE_PFM && $fell(act_out[2]));

endmodule

// *** testbench/actuator_load.sv ***
// Field actuator model: reports a wired short on the sense lines on command
module actuator_load
    import do8_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] act_out,
    input  wire logic [7:0] shorted,
    output logic      [7:0] short_in
);
    // Sense is a wiring fault level, not load current, so it does not chatter
    // when the stage falls back to off
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            short_in <= 8'h00;
        else
            short_in <= shorted;
    end
endmodule

// *** testbench/digital_output_channel_modes_bench.sv ***
// Self-checking bench for the eight-channel output stage
module digital_output_channel_modes_bench
    import do8_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            mclk = 1'b0;
    logic            resetn = 1'b0;
    reg_req_t        req = '0;
    logic [31:0]     rdata;
    logic [7:0][7:0] proc_value = '0;
    logic [7:0]      fault_in = 8'h00;
    logic [7:0]      shorted = 8'h00;
    logic [7:0]      short_in;
    logic [7:0]      act_out;
    logic            irq;
    int              miscompares = 0;
    int              compares = 0;

    always #5 mclk = ~mclk;

    // Short tick and slow step keep every timed scenario within a few thousand cycles
    do8_ctrl #(.TICK_CYC(10), .SLOW_CYC(20)) u_do8_ctrl (
        .mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
        .proc_value(proc_value), .fault_in(fault_in), .short_in(short_in),
        .act_out(act_out), .irq(irq));

    actuator_load u_actuator_load (
        .mclk(mclk), .resetn(resetn), .act_out(act_out), .shorted(shorted),
        .short_in(short_in));

    // ------------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    task automatic apply(input int ch, input logic [7:0] v, input logic [7:0] exp);
        @(posedge mclk);
        proc_value[ch] <= v;
        repeat (3) @(posedge mclk);
        #1 check({24'h0, act_out}, {24'h0, exp});
    endtask

    task automatic count_on(input int ch, input int n, output int hi);
        hi = 0;
        repeat (n)
        begin
            @(posedge mclk);
            // An unknown level counts heavily so that no expected count can absorb it
            #1 hi += (act_out[ch] === 1'b1) ? 1 : ((act_out[ch] === 1'b0) ? 0 : 100000);
        end
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        expect_reg(8'h00, 32'h00000140);
        expect_reg(8'h1c, 32'h00000140);
        expect_reg(8'h20, 32'h00006400);
        expect_reg(8'h40, 32'h00000000);
        expect_reg(8'h80, 32'h00000000);
        apply(0, 8'd200, 8'h00);
        apply(0, 8'd0, 8'h00);
    endtask

    task automatic t_onoff();
        wr(8'h00, 32'h00000141);
        apply(0, 8'd5, 8'h01);
        apply(0, 8'd255, 8'h01);
        apply(0, 8'd0, 8'h00);
        wr(8'h00, 32'h00000161);
        apply(0, 8'd0, 8'h01);
        apply(0, 8'd9, 8'h00);
        apply(0, 8'd0, 8'h01);
        wr(8'h00, 32'h00000147);
        apply(0, 8'd5, 8'h00);
        apply(0, 8'd0, 8'h00);
        wr(8'h00, 32'h00000141);
    endtask

    task automatic t_thresh();
        wr(8'h24, 32'h00006414);
        wr(8'h04, 32'h00000142);
        apply(1, 8'd101, 8'h02);
        apply(1, 8'd50, 8'h02);
        apply(1, 8'd19, 8'h00);
        apply(1, 8'd100, 8'h00);
        wr(8'h04, 32'h00000152);
        apply(1, 8'd50, 8'h02);
        apply(1, 8'd101, 8'h00);
        apply(1, 8'd20, 8'h02);
        apply(1, 8'd19, 8'h00);
    endtask

    task automatic t_fault();
        apply(0, 8'd1, 8'h01);
        @(posedge mclk);
        fault_in[0] <= 1'b1;
        apply(0, 8'd1, 8'h00);
        wr(8'h00, 32'h00000181);
        apply(0, 8'd0, 8'h01);
        wr(8'h00, 32'h00000101);
        apply(0, 8'd0, 8'h01);
        wr(8'h00, 32'h000001c1);
        apply(0, 8'd0, 8'h01);
        wr(8'h44, 32'h00000100);
        #1 check({31'h0, irq}, 32'h1);
        @(posedge mclk);
        fault_in[0] <= 1'b0;
        wr(8'h40, 32'h0000ffff);
        expect_reg(8'h40, 32'h00000000);
        check({31'h0, irq}, 32'h0);
        wr(8'h00, 32'h00000141);
    endtask

    task automatic t_short();
        wr(8'h08, 32'h00000141);
        apply(2, 8'd1, 8'h04);
        @(posedge mclk);
        shorted[2] <= 1'b1;
        apply(2, 8'd1, 8'h00);
        expect_reg(8'h40, 32'h00000404);
        wr(8'h44, 32'h00000004);
        #1 check({31'h0, irq}, 32'h1);
        wr(8'h08, 32'h00000041);
        wr(8'h40, 32'h0000ffff);
        apply(2, 8'd1, 8'h04);
        expect_reg(8'h40, 32'h00000000);
        @(posedge mclk);
        shorted[2] <= 1'b0;
        apply(2, 8'd0, 8'h00);
    endtask

    task automatic t_delay();
        wr(8'h0c, 32'h03000141);
        @(posedge mclk);
        proc_value[3] <= 8'd1;
        repeat (10) @(posedge mclk);
        proc_value[3] <= 8'd0;
        repeat (60) @(posedge mclk);
        #1 check({24'h0, act_out}, 32'h0);
        @(posedge mclk);
        proc_value[3] <= 8'd1;
        repeat (15) @(posedge mclk);
        #1 check({24'h0, act_out}, 32'h0);
        repeat (45) @(posedge mclk);
        #1 check({24'h0, act_out}, 32'h08);
        apply(3, 8'd0, 8'h08);
    endtask

    task automatic t_modulate();
        int hi;
        wr(8'h10, 32'h0000014b);
        @(posedge mclk);
        proc_value[4] <= 8'd30;
        repeat (2200) @(posedge mclk);
        count_on(4, 2000, hi);
        check({31'h0, hi inside {[580:620]}}, 32'h1);
        wr(8'h10, 32'h00000143);
        @(posedge mclk);
        proc_value[4] <= 8'd100;
        repeat (600) @(posedge mclk);
        count_on(4, 1000, hi);
        check(hi, 32'd1000);
        wr(8'h10, 32'h00000144);
        @(posedge mclk);
        proc_value[4] <= 8'd0;
        repeat (20) @(posedge mclk);
        count_on(4, 1000, hi);
        check(hi, 32'd0);
    endtask

    task automatic t_reduce();
        logic [31:0] d;
        wr(8'h34, 32'h00036400);
        wr(8'h14, 32'h0000cb41);
        apply(5, 8'd1, 8'h20);
        expect_reg(8'h48, 32'h00000020);
        repeat (60) @(posedge mclk);
        rd(8'h48, d);
        check({31'h0, d[13]}, 32'h1);
        wr(8'h14, 32'h00000341);
        apply(5, 8'd1, 8'h00);
        wr(8'h14, 32'h00000141);
        apply(5, 8'd1, 8'h20);
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_onoff();
        t_thresh();
        t_fault();
        t_short();
        t_delay();
        t_modulate();
        t_reduce();
        conclude();
    end

    // Scenarios need under ten thousand cycles; this leaves ample margin
    initial
    begin
        repeat (30000) @(posedge mclk);
        miscompares++;
        conclude();
    end
endmodule
